// ===== logic/vow_defines.vh
`ifndef VOW_DEFINES_VH
`define VOW_DEFINES_VH

// Crtc index and data ports
`define VOW_PORT_INDEX 16'h03D4
`define VOW_PORT_DATA 16'h03D5

// Crtc register indices
`define VOW_IDX_HBLANK_START 8'h02
`define VOW_IDX_HBLANK_END_LOW 8'h03
`define VOW_IDX_HRETRACE_END 8'h05
`define VOW_IDX_VERT_OVERFLOW 8'h07
`define VOW_IDX_MAX_SCANLINE 8'h09
`define VOW_IDX_VBLANK_START 8'h15
`define VOW_IDX_VBLANK_END 8'h16
`define VOW_IDX_OVL_BLANK_EXT 8'h1A
`define VOW_IDX_BLANK_CTRL 8'h1B
`define VOW_IDX_OVL_CTRL 8'h1D
`define VOW_IDX_STATUS 8'h3F

// Field positions
`define VOW_HBE_LOW_MSB 4
`define VOW_HBE_BIT5_POS 7
`define VOW_VBS_BIT8_POS 3
`define VOW_VBS_BIT9_POS 5
`define VOW_SEL_LSB 2
`define VOW_SEL_MSB 3
`define VOW_HBE_HI_LSB 4
`define VOW_HBE_HI_MSB 5
`define VOW_VBE_HI_LSB 6
`define VOW_VBE_HI_MSB 7
`define VOW_WGEN_EN_POS 5
`define VOW_WSRC_POS 6

// Switch select and pixel transfer mode encodings
`define VOW_SEL_OFF 2'h0
`define VOW_SEL_PIN_OR_WIN 2'h1
`define VOW_SEL_KEY_AND 2'h2
`define VOW_XFER_PARALLEL16 3'h3

// Reset values
`define VOW_REG_RESET 8'h00

// Pixel clock limits in MHz
`define VOW_MAX_PCLK_PLAIN_MHZ 50
`define VOW_MAX_PCLK_INTERP_MHZ 80

`endif

// ===== logic/vow_fifo.v
`timescale 1ns/1ps
module vow_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clk_in,
  input wire reset_n_in,
  // Fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  // Drain side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  assign in_ready_out = (count_q != DEPTH[AW:0]);
  assign out_valid_out = (count_q != {(AW+1){1'b0}});
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem_q[rd_ptr_q];

  always @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // vow_fifo

// ===== logic/vow_overlay_switch.v
`timescale 1ns/1ps
`include "vow_defines.vh"
module vow_overlay_switch #(
  parameter H_TOTAL = 8'd100,
  parameter H_DISP = 8'd80,
  parameter V_TOTAL = 10'd525,
  parameter V_DISP = 10'd480,
  parameter VCO_AUTO_ON_OVERLAY = 1'b0,
  parameter FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire clk_in,
  input wire reset_n_in,
  // Crtc port access
  input wire [15:0] io_addr_in,
  input wire io_wr_in,
  input wire io_rd_in,
  input wire [7:0] io_wdata_in,
  output reg [7:0] io_rdata_out,
  // Loose configuration bits
  input wire pci_host_bus_in,
  input wire expansion_rom_enable_in,
  input wire pixel_bus_ext_enable_in,
  input wire interp_enable_in,
  input wire [2:0] pixel_transfer_mode_in,
  input wire memory_override_in,
  input wire [7:0] color_key_value_in,
  input wire [7:0] color_key_mask_in,
  input wire vco_on_memclk_strap_n_in,
  // Link pins
  input wire dot_clock_in,
  input wire ext_overlay_enable_n_in,
  input wire ext_dot_clock_select_n_in,
  input wire [15:0] pixel_bus_in,
  output reg [7:0] pixel_bus_out,
  output wire pixel_bus_oe_out,
  output reg window_active_n_out,
  output reg dac_blank_n_out,
  output reg memclk_vco_select_out,
  output wire clock_doubling_out,
  // Display memory pixels, same clock
  input wire [15:0] mem_pixel_in,
  // Pixel stream to the dac
  output wire pixel_fifo_ready_out,
  output wire dac_valid_out,
  input wire dac_ready_in,
  output wire [15:0] dac_pixel_out
);
  // Register file
  reg [7:0] index_q;
  reg [7:0] hbs_q;
  reg [7:0] hbe_low_q;
  reg [7:0] hre_q;
  reg [7:0] vovf_q;
  reg [7:0] msl_q;
  reg [7:0] vbs_q;
  reg [7:0] vbe_q;
  reg [7:0] ovl_q;
  reg [7:0] bctl_q;
  reg [7:0] octl_q;

  // Pin synchronisers
  reg [2:0] dot_clock_in_sync_q;
  reg [2:0] evid_sync_q;
  reg evid_q;
  reg [15:0] pbus_s1_q;
  reg [15:0] pbus_s2_q;
  reg [15:0] pbus_s3_q;

  // Timing generator
  reg [1:0] dot_q;
  reg [7:0] hcnt_q;
  reg [9:0] vcnt_q;
  reg hblank_q;
  reg vblank_q;
  reg strap_done_q;
  reg strap_vco_q;

  // Interpolation pipeline
  reg phase_q;
  reg [15:0] samp_a_q;
  reg [15:0] samp_b_q;
  reg sw_b_q;
  reg [15:0] mem_d1_q;
  reg [15:0] mem_d2_q;
  reg sw_d1_q;
  reg sw_d2_q;
  reg [15:0] pix_q;
  reg pix_valid_q;

  wire [1:0] sel;
  wire win_src;
  wire win_gen;
  wire [7:0] hbe_full;
  wire [9:0] vbs_full;
  wire [9:0] vbe_full;
  wire dot_edge;
  wire h_disp;
  wire v_disp;
  wire disp_en;
  wire hb_end_hit;
  wire vb_end_hit;
  wire window_on;
  wire key_match;
  wire ext_active;
  wire interp_on;
  wire [15:0] bus_pix;
  wire [5:0] avg_r;
  wire [6:0] avg_g;
  wire [5:0] avg_b;
  wire [15:0] avg_pix;
  reg switch_on;
  reg [15:0] out_pix;

  assign sel = ovl_q[`VOW_SEL_MSB:`VOW_SEL_LSB];
  assign win_src = octl_q[`VOW_WSRC_POS];
  assign win_gen = bctl_q[`VOW_WGEN_EN_POS];
  assign hbe_full = {ovl_q[`VOW_HBE_HI_MSB:`VOW_HBE_HI_LSB], hre_q[`VOW_HBE_BIT5_POS],
    hbe_low_q[`VOW_HBE_LOW_MSB:0]};
  assign vbs_full = {msl_q[`VOW_VBS_BIT9_POS], vovf_q[`VOW_VBS_BIT8_POS], vbs_q};
  assign vbe_full = {ovl_q[`VOW_VBE_HI_MSB:`VOW_VBE_HI_LSB], vbe_q};

  // Port writes through index and data
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      index_q <= `VOW_REG_RESET;
      hbs_q <= `VOW_REG_RESET;
      hbe_low_q <= `VOW_REG_RESET;
      hre_q <= `VOW_REG_RESET;
      vovf_q <= `VOW_REG_RESET;
      msl_q <= `VOW_REG_RESET;
      vbs_q <= `VOW_REG_RESET;
      vbe_q <= `VOW_REG_RESET;
      ovl_q <= `VOW_REG_RESET;
      bctl_q <= `VOW_REG_RESET;
      octl_q <= `VOW_REG_RESET;
    end else if (io_wr_in) begin
      if (io_addr_in == `VOW_PORT_INDEX) begin
        index_q <= io_wdata_in;
      end else if (io_addr_in == `VOW_PORT_DATA) begin
        if (index_q == `VOW_IDX_HBLANK_START) begin
          hbs_q <= io_wdata_in;
        end else if (index_q == `VOW_IDX_HBLANK_END_LOW) begin
          hbe_low_q <= io_wdata_in;
        end else if (index_q == `VOW_IDX_HRETRACE_END) begin
          hre_q <= io_wdata_in;
        end else if (index_q == `VOW_IDX_VERT_OVERFLOW) begin
          vovf_q <= io_wdata_in;
        end else if (index_q == `VOW_IDX_MAX_SCANLINE) begin
          msl_q <= io_wdata_in;
        end else if (index_q == `VOW_IDX_VBLANK_START) begin
          vbs_q <= io_wdata_in;
        end else if (index_q == `VOW_IDX_VBLANK_END) begin
          vbe_q <= io_wdata_in;
        end else if (index_q == `VOW_IDX_OVL_BLANK_EXT) begin
          ovl_q <= io_wdata_in;
        end else if (index_q == `VOW_IDX_BLANK_CTRL) begin
          bctl_q <= io_wdata_in;
        end else if (index_q == `VOW_IDX_OVL_CTRL) begin
          octl_q <= io_wdata_in;
        end
      end
    end
  end

  // Registered read data, unmapped reads return zero
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      io_rdata_out <= 8'h00;
    end else if (io_rd_in) begin
      if (io_addr_in == `VOW_PORT_INDEX) begin
        io_rdata_out <= index_q;
      end else if (io_addr_in == `VOW_PORT_DATA) begin
        if (index_q == `VOW_IDX_HBLANK_START) begin
          io_rdata_out <= hbs_q;
        end else if (index_q == `VOW_IDX_HBLANK_END_LOW) begin
          io_rdata_out <= hbe_low_q;
        end else if (index_q == `VOW_IDX_HRETRACE_END) begin
          io_rdata_out <= hre_q;
        end else if (index_q == `VOW_IDX_VERT_OVERFLOW) begin
          io_rdata_out <= vovf_q;
        end else if (index_q == `VOW_IDX_MAX_SCANLINE) begin
          io_rdata_out <= msl_q;
        end else if (index_q == `VOW_IDX_VBLANK_START) begin
          io_rdata_out <= vbs_q;
        end else if (index_q == `VOW_IDX_VBLANK_END) begin
          io_rdata_out <= vbe_q;
        end else if (index_q == `VOW_IDX_OVL_BLANK_EXT) begin
          io_rdata_out <= ovl_q;
        end else if (index_q == `VOW_IDX_BLANK_CTRL) begin
          io_rdata_out <= bctl_q;
        end else if (index_q == `VOW_IDX_OVL_CTRL) begin
          io_rdata_out <= octl_q;
        end else if (index_q == `VOW_IDX_STATUS) begin
          io_rdata_out <= {4'h0, strap_vco_q, disp_en, vblank_q, hblank_q};
        end else begin
          io_rdata_out <= 8'h00;
        end
      end else begin
        io_rdata_out <= 8'h00;
      end
    end
  end

  // Three-stage pin capture; a dot clock or overlay enable change counts when stages two and three agree
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dot_clock_in_sync_q <= 3'h0;
      evid_sync_q <= 3'h7;
      evid_q <= 1'b1;
      pbus_s1_q <= 16'h0000;
      pbus_s2_q <= 16'h0000;
      pbus_s3_q <= 16'h0000;
      dot_q <= 2'h0;
    end else begin
      dot_clock_in_sync_q <= {dot_clock_in_sync_q[1:0], dot_clock_in};
      evid_sync_q <= {evid_sync_q[1:0], ext_overlay_enable_n_in};
      if (evid_sync_q[1] == evid_sync_q[2]) begin
        evid_q <= evid_sync_q[2];
      end
      pbus_s1_q <= pixel_bus_in;
      pbus_s2_q <= pbus_s1_q;
      pbus_s3_q <= pbus_s2_q;
      if (dot_clock_in_sync_q[1] == dot_clock_in_sync_q[2]) begin
        dot_q <= {dot_q[0], dot_clock_in_sync_q[2]};
      end
    end
  end

  // Rising edge of the filtered dot clock is the pixel enable
  assign dot_edge = dot_q[0] & ~dot_q[1];

  // Character and line counters; hcnt steps once per eight pixels
  reg [2:0] pix_in_char_q;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pix_in_char_q <= 3'h0;
      hcnt_q <= 8'h00;
      vcnt_q <= 10'h000;
    end else if (dot_edge) begin
      pix_in_char_q <= pix_in_char_q + 3'h1;
      if (pix_in_char_q == 3'h7) begin
        if (hcnt_q == H_TOTAL - 8'd1) begin
          hcnt_q <= 8'h00;
          vcnt_q <= (vcnt_q == V_TOTAL - 10'd1) ? 10'h000 : vcnt_q + 10'd1;
        end else begin
          hcnt_q <= hcnt_q + 8'd1;
        end
      end
    end
  end

  assign h_disp = (hcnt_q < H_DISP);
  assign v_disp = (vcnt_q < V_DISP);
  assign disp_en = h_disp & v_disp;
  // Window mode compares all end bits, normal mode only the low ones
  assign hb_end_hit = win_gen ? (hcnt_q == hbe_full) : (hcnt_q[5:0] == hbe_full[5:0]);
  assign vb_end_hit = win_gen ? (vcnt_q == vbe_full) : (vcnt_q[7:0] == vbe_full[7:0]);

  // Set/clear flags: one start and one end each, so one rectangle only;
  // the end is seen a count after the start, so the second position cannot bound
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hblank_q <= 1'b0;
      vblank_q <= 1'b0;
    end else if (dot_edge && pix_in_char_q == 3'h7) begin
      if (hcnt_q == hbs_q) begin
        hblank_q <= 1'b1;
      end else if (hblank_q && hb_end_hit) begin
        hblank_q <= 1'b0;
      end
      if (hcnt_q == H_TOTAL - 8'd1) begin
        if (vcnt_q == vbs_full) begin
          vblank_q <= 1'b1;
        end else if (vblank_q && vb_end_hit) begin
          vblank_q <= 1'b0;
        end
      end
    end
  end

  assign window_on = win_gen & hblank_q & vblank_q;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      window_active_n_out <= 1'b1;
      dac_blank_n_out <= 1'b0;
    end else begin
      window_active_n_out <= ~window_on;
      dac_blank_n_out <= win_gen ? disp_en : ~(hblank_q | vblank_q);
    end
  end

  // Strap caught once after reset release
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_done_q <= 1'b0;
      strap_vco_q <= 1'b0;
      memclk_vco_select_out <= 1'b0;
    end else begin
      if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        strap_vco_q <= ~vco_on_memclk_strap_n_in;
      end
      memclk_vco_select_out <= strap_vco_q | (VCO_AUTO_ON_OVERLAY & (sel != `VOW_SEL_OFF));
    end
  end

  // Switch source selection
  assign key_match = (((mem_pixel_in[7:0] ^ color_key_value_in) & ~color_key_mask_in) == 8'h00);
  always @* begin
    switch_on = 1'b0;
    case (sel)
      `VOW_SEL_PIN_OR_WIN: switch_on = win_src ? window_on : ~evid_q;
      `VOW_SEL_KEY_AND: switch_on = key_match & (win_src ? window_on : ~evid_q);
      default: switch_on = 1'b0;
    endcase
  end

  assign pixel_bus_oe_out = (sel == `VOW_SEL_OFF);
  assign ext_active = pci_host_bus_in & ~expansion_rom_enable_in & pixel_bus_ext_enable_in;
  // Rated to 80 MHz pixel clock only; not checked here
  assign interp_on = ext_active & interp_enable_in;
  assign clock_doubling_out = interp_on & (pixel_transfer_mode_in == `VOW_XFER_PARALLEL16);
  assign bus_pix = ext_active ? pbus_s3_q : {8'h00, pbus_s3_q[7:0]};

  // Channel-wise average of two rgb565 samples
  assign avg_r = {1'b0, samp_a_q[15:11]} + {1'b0, samp_b_q[15:11]};
  assign avg_g = {1'b0, samp_a_q[10:5]} + {1'b0, samp_b_q[10:5]};
  assign avg_b = {1'b0, samp_a_q[4:0]} + {1'b0, samp_b_q[4:0]};
  assign avg_pix = {avg_r[5:1], avg_g[6:1], avg_b[5:1]};

  // Interpolation delays the stream two pixels to see the following sample
  always @* begin
    out_pix = mem_pixel_in;
    if (interp_on) begin
      if (sw_d2_q && !memory_override_in) begin
        out_pix = phase_q ? (sw_b_q ? avg_pix : samp_a_q) : samp_b_q;
      end else begin
        out_pix = mem_d2_q;
      end
    end else if (switch_on && !memory_override_in) begin
      out_pix = bus_pix;
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_q <= 1'b0;
      samp_a_q <= 16'h0000;
      samp_b_q <= 16'h0000;
      sw_b_q <= 1'b0;
      mem_d1_q <= 16'h0000;
      mem_d2_q <= 16'h0000;
      sw_d1_q <= 1'b0;
      sw_d2_q <= 1'b0;
      pix_q <= 16'h0000;
      pix_valid_q <= 1'b0;
      pixel_bus_out <= 8'h00;
    end else begin
      pix_valid_q <= dot_edge;
      if (dot_edge) begin
        phase_q <= (pix_in_char_q == 3'h7 && hcnt_q == H_TOTAL - 8'd1) ? 1'b0 : ~phase_q;
        if (!phase_q) begin
          samp_a_q <= samp_b_q;
          samp_b_q <= bus_pix;
          sw_b_q <= switch_on;
        end
        mem_d1_q <= mem_pixel_in;
        mem_d2_q <= mem_d1_q;
        sw_d1_q <= switch_on;
        sw_d2_q <= sw_d1_q;
        pix_q <= out_pix;
        pixel_bus_out <= mem_pixel_in[7:0];
      end
    end
  end

  vow_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH),
    .AW(5)
  ) u_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(pix_valid_q),
    .in_ready_out(pixel_fifo_ready_out),
    .in_data_in(pix_q),
    .out_valid_out(dac_valid_out),
    .out_ready_in(dac_ready_in),
    .out_data_out(dac_pixel_out)
  );
endmodule // vow_overlay_switch

// ===== tb/vow_overlay_switch_sva.sv
`timescale 1ns/1ps
module vow_overlay_switch_sva (
  // Clock and reset
  input wire clk_in,
  input wire reset_n_in,
  // Register port
  input wire [15:0] io_addr_in,
  input wire io_wr_in,
  input wire io_rd_in,
  input wire [7:0] io_wdata_in,
  input wire [7:0] io_rdata_out,
  // Configuration
  input wire pci_host_bus_in,
  input wire expansion_rom_enable_in,
  input wire pixel_bus_ext_enable_in,
  input wire interp_enable_in,
  input wire [2:0] pixel_transfer_mode_in,
  input wire vco_on_memclk_strap_n_in,
  // Outputs, plus the dac ready input
  input wire pixel_bus_oe_out,
  input wire window_active_n_out,
  input wire memclk_vco_select_out,
  input wire clock_doubling_out,
  input wire dac_valid_out,
  input wire dac_ready_in,
  input wire [15:0] dac_pixel_out
);
  reg [7:0] idx_q;
  reg [7:0] ovl_q;
  reg wgen_q;
  reg [1:0] age_q;
  wire data_rd = io_rd_in && io_addr_in == 16'h03D5;
  wire data_wr = io_wr_in && io_addr_in == 16'h03D5;
  wire ext_on = pci_host_bus_in && !expansion_rom_enable_in && pixel_bus_ext_enable_in;
  // Shadow only the fields whose effect shows at the ports
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      idx_q <= 8'h00;
      ovl_q <= 8'h00;
      wgen_q <= 1'b0;
      age_q <= 2'h0;
    end else begin
      if (age_q != 2'h3) age_q <= age_q + 2'h1;
      if (io_wr_in && io_addr_in == 16'h03D4) idx_q <= io_wdata_in;
      if (data_wr && idx_q == 8'h1A) ovl_q <= io_wdata_in;
      if (data_wr && idx_q == 8'h1B) wgen_q <= io_wdata_in[5];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  AST_OE_SELECT: assert property (pixel_bus_oe_out == (ovl_q[3:2] == 2'h0))
    else $error("pixel bus drive enable wrong for select");
  AST_OE_AFTER_RESET: assert property (age_q != 2'h3 |-> pixel_bus_oe_out)
    else $error("pixel bus not driven after reset");
  AST_DBL_NEEDS_EXT: assert property (clock_doubling_out |-> ext_on && interp_enable_in)
    else $error("doubling without bus extension");
  AST_DBL_ON: assert property (ext_on && interp_enable_in && pixel_transfer_mode_in == 3'h3 |-> clock_doubling_out)
    else $error("doubling not enabled");
  AST_VCO_ROUTE: assert property (age_q == 2'h3 |-> memclk_vco_select_out == !vco_on_memclk_strap_n_in)
    else $error("oscillator routing disagrees with strap");
  AST_OVL_READBACK: assert property (data_rd && idx_q == 8'h1A |=> io_rdata_out == $past(ovl_q))
    else $error("overlay register read back wrong");
  AST_UNMAPPED_ZERO: assert property (data_rd && idx_q == 8'h40 |=> io_rdata_out == 8'h00)
    else $error("unmapped index did not read zero");
  AST_RDATA_HOLDS: assert property (!io_rd_in |=> $stable(io_rdata_out))
    else $error("read data changed without a read");
  AST_WINDOW_OFF: assert property (!wgen_q && !$past(wgen_q) |-> window_active_n_out)
    else $error("window active with generator disabled");
  AST_DAC_HOLD: assert property (dac_valid_out && !dac_ready_in |=> dac_valid_out && $stable(dac_pixel_out))
    else $error("dac word dropped while stalled");
  COV_POP: cover property (dac_valid_out && dac_ready_in);
  COV_WIN: cover property ($fell(window_active_n_out));
  COV_DBL: cover property (clock_doubling_out);
endmodule // vow_overlay_switch_sva

bind vow_overlay_switch vow_overlay_switch_sva vow_overlay_switch_sva_inst (.clk_in, .reset_n_in,
  .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in, .io_rdata_out, .pci_host_bus_in,
  .expansion_rom_enable_in, .pixel_bus_ext_enable_in, .interp_enable_in, .pixel_transfer_mode_in,
  .vco_on_memclk_strap_n_in, .pixel_bus_oe_out, .window_active_n_out, .memclk_vco_select_out,
  .clock_doubling_out, .dac_valid_out, .dac_ready_in, .dac_pixel_out);

// ===== tb/vow_video_src.sv
`timescale 1ns/1ps
module vow_video_src (
  // Bench control
  input wire static_pass_in,
  input wire follow_window_in,
  // Link pins
  input wire window_active_n_in,
  output reg dot_clock_out,
  output reg ext_overlay_enable_n_out,
  output wire ext_dot_clock_select_n_out,
  output reg [15:0] pixel_bus_out
);
  // Clock comes from this side in every overlay mode
  assign ext_dot_clock_select_n_out = 1'b0;
  initial begin
    dot_clock_out = 1'b0;
    ext_overlay_enable_n_out = 1'b1;
    pixel_bus_out = 16'h0040;
    #3;
    forever #40 dot_clock_out = ~dot_clock_out;
  end
  // Low byte stays in 40..7F so bus pixels never look like memory pixels
  always @(negedge dot_clock_out) begin
    pixel_bus_out <= {pixel_bus_out[15:8] + 8'h01, 2'h1, pixel_bus_out[5:0] + 6'h01};
    ext_overlay_enable_n_out <= static_pass_in ? 1'b0 : (follow_window_in ? window_active_n_in : 1'b1);
  end
endmodule // vow_video_src

// ===== tb/vow_overlay_switch_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  num_checks = num_checks + 1; \
  if ((got) !== (ex)) begin \
    num_errors = num_errors + 1; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); \
  end \
end
module vow_overlay_switch_tb_top;
  reg clk_in, reset_n_in, io_wr, io_rd, pci, rom, ext, interp, ovr, stat, follow, dac_ready, strap_n;
  reg [2:0] mode;
  reg [15:0] io_addr, mem_pix;
  reg [7:0] io_wdata, key, mask;
  wire oe, win_n, blank_n, memclk_sel, dbl, fifo_rdy, dac_valid, dot, ovl_en_n, dcs_n;
  wire [7:0] rdata, pbus_o;
  wire [15:0] pbus, dac_pixel;
  integer num_errors, num_checks, i, n, nmem, nbus, nwin, nblk;
  reg [10:0] cases [0:11];
  reg [7:0] idxs [0:7];
  vow_overlay_switch #(.H_TOTAL(8'h04), .H_DISP(8'h03), .V_TOTAL(10'h004), .V_DISP(10'h003)) vow_overlay_switch_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .io_addr_in(io_addr), .io_wr_in(io_wr), .io_rd_in(io_rd),
    .io_wdata_in(io_wdata), .io_rdata_out(rdata), .pci_host_bus_in(pci), .expansion_rom_enable_in(rom),
    .pixel_bus_ext_enable_in(ext), .interp_enable_in(interp), .pixel_transfer_mode_in(mode),
    .memory_override_in(ovr), .color_key_value_in(key), .color_key_mask_in(mask),
    .vco_on_memclk_strap_n_in(strap_n), .dot_clock_in(dot), .ext_overlay_enable_n_in(ovl_en_n),
    .ext_dot_clock_select_n_in(dcs_n), .pixel_bus_in(pbus), .pixel_bus_out(pbus_o), .pixel_bus_oe_out(oe),
    .window_active_n_out(win_n), .dac_blank_n_out(blank_n), .memclk_vco_select_out(memclk_sel),
    .clock_doubling_out(dbl), .mem_pixel_in(mem_pix), .pixel_fifo_ready_out(fifo_rdy),
    .dac_valid_out(dac_valid), .dac_ready_in(dac_ready), .dac_pixel_out(dac_pixel));
  vow_video_src vow_video_src_inst (.static_pass_in(stat), .follow_window_in(follow),
    .window_active_n_in(win_n), .dot_clock_out(dot), .ext_overlay_enable_n_out(ovl_en_n),
    .ext_dot_clock_select_n_out(dcs_n), .pixel_bus_out(pbus));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task conclude;
    begin
      if (num_errors == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Idle cycle after each access so strobes never toggle twice in one step
  task bus(input [15:0] a, input w, input [7:0] d);
    begin
      io_addr <= a;
      io_wr <= w;
      io_rd <= !w;
      io_wdata <= d;
      @(posedge clk_in);
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  task wr(input [7:0] idx, input [7:0] d);
    begin
      bus(16'h03D4, 1'b1, idx);
      bus(16'h03D5, 1'b1, d);
    end
  endtask
  task rd_chk(input [7:0] idx, input [7:0] ex);
    begin
      bus(16'h03D4, 1'b1, idx);
      bus(16'h03D5, 1'b0, 8'h00);
      `CHK("register read", ex, rdata)
    end
  endtask
  // Classify popped pixels by low byte: A5 memory, 40..7F bus
  task sample;
    begin
      nmem = 0;
      nbus = 0;
      nwin = 0;
      nblk = 0;
      repeat (400) @(posedge clk_in);
      repeat (800) begin
        @(posedge clk_in);
        if (win_n === 1'b0) nwin = nwin + 1;
        // Window lies inside the display area, so blank must be off there
        if (win_n === 1'b0 && blank_n !== 1'b1) nblk = nblk + 1;
        if (dac_valid === 1'b1 && dac_pixel[7:0] === 8'hA5) nmem = nmem + 1;
        if (dac_valid === 1'b1 && dac_pixel[7:6] === 2'h1) nbus = nbus + 1;
      end
    end
  endtask
  initial begin
    repeat (100000) @(posedge clk_in);
    num_errors = num_errors + 1;
    conclude;
  end
  initial begin
    // {interp, expect, select, source, window gen, static, override, key off, mask}
    cases = '{11'h008, 11'h148, 11'h04C, 11'h188, 11'h080, 11'h18B, 11'h08A, 11'h2B8, 11'h270, 11'h250,
      11'h44C, 11'h548};
    idxs = '{8'h02, 8'h03, 8'h05, 8'h07, 8'h09, 8'h15, 8'h16, 8'h1A};
    num_errors = 0;
    num_checks = 0;
    reset_n_in = 1'b0;
    {io_addr, io_wr, io_rd, io_wdata} = 26'h0000000;
    {pci, rom, ext, interp, ovr, stat, follow} = 7'h00;
    key = 8'hA5;
    mask = 8'h00;
    dac_ready = 1'b1;
    mode = 3'h3;
    strap_n = 1'b0;
    mem_pix = 16'h5AA5;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    for (i = 0; i < 8; i = i + 1) rd_chk(idxs[i], 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      wr(idxs[i], ~idxs[i]);
      rd_chk(idxs[i], ~idxs[i]);
      wr(idxs[i], 8'h00);
    end
    wr(8'h40, 8'h77);
    rd_chk(8'h40, 8'h00);
    wr(8'h1A, 8'hC0);
    bus(16'h03D6, 1'b1, 8'h0C);
    rd_chk(8'h1A, 8'hC0);
    `CHK("oscillator routing", 1'b1, memclk_sel)
    `CHK("pixel bus out", 8'hA5, pbus_o)
    interp <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      {pci, rom, ext} <= i[2:0];
      repeat (2) @(posedge clk_in);
      `CHK("clock doubling", i == 5, dbl)
    end
    {pci, rom, ext} <= 3'h5;
    mode <= 3'h1;
    repeat (2) @(posedge clk_in);
    `CHK("doubling needs parallel mode", 1'b0, dbl)
    mode <= 3'h3;
    interp <= 1'b0;
    repeat (2) @(posedge clk_in);
    `CHK("clock doubling off", 1'b0, dbl)
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h1A, i[7:0] << 2);
      `CHK("pixel bus drive", i == 0, oe)
    end
    wr(8'h03, 8'h02);
    wr(8'h16, 8'h02);
    for (i = 0; i < 12; i = i + 1) begin
      interp <= cases[i][10];
      {pci, rom, ext} <= {cases[i][10], 1'b0, cases[i][10]};
      wr(8'h1A, {4'h0, cases[i][7:6], 2'h0});
      wr(8'h1B, {2'h0, cases[i][4], 5'h00});
      wr(8'h1D, {1'b0, cases[i][5], 6'h00});
      stat <= cases[i][3];
      ovr <= cases[i][2];
      key <= cases[i][1] ? 8'hA6 : 8'hA5;
      mask <= cases[i][0] ? 8'h03 : 8'h00;
      follow <= cases[i][6];
      sample;
      `CHK("memory pixels", cases[i][9:8] != 2'h1, nmem > 0)
      `CHK("bus pixels", cases[i][9:8] != 2'h0, nbus > 0)
      `CHK("window seen", cases[i][4], nwin > 0)
      `CHK("blank inside window", 0, nblk)
    end
    wr(8'h1A, 8'h00);
    dac_ready <= 1'b0;
    n = 0;
    while (fifo_rdy !== 1'b0 && n < 4000) begin
      @(posedge clk_in);
      n = n + 1;
    end
    `CHK("fifo full", 1'b0, fifo_rdy)
    if (fifo_rdy !== 1'b0) conclude;
    repeat (20) @(posedge clk_in);
    dac_ready <= 1'b1;
    n = 0;
    while (dac_valid !== 1'b0 && n < 400) begin
      @(posedge clk_in);
      n = n + 1;
    end
    `CHK("fifo drained", 1'b1, n >= 32 && n < 400)
    wr(8'h1A, 8'h04);
    strap_n <= 1'b1;
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    `CHK("drive after reset", 1'b1, oe)
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    rd_chk(8'h1A, 8'h00);
    `CHK("oscillator routing off", 1'b0, memclk_sel)
    conclude;
  end
endmodule // vow_overlay_switch_tb_top
